// ==== rtl/two_wire_unit.sv ====
/*
 * Two-wire bus master transmitter with AXI4-Lite control, status and data registers.
 * Assumes open-drain pads outside (low while an enable is high) and an asynchronous bus.
 */
module two_wire_unit
   import two_wire_pkg::*;
#(
   parameter int QUARTER = QUARTER_CYCLES
)
(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // two-wire bus pads
   input  wire logic              scl_in,
   output logic                   scl_out,
   output logic                   scl_oe,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   // interrupt request
   output logic                   irq
);

   typedef enum logic [2:0] {
      M_IDLE      = 3'b000,
      M_WAIT_FREE = 3'b001,
      M_START     = 3'b010,
      M_HOLD      = 3'b011,
      M_BYTE      = 3'b100,
      M_STOP      = 3'b101
   } mst_state_t;

   function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
      case (addr)
         CTRL_OFFSET:   reg_sel = 2'h0;
         STATUS_OFFSET: reg_sel = 2'h1;
         DATA_OFFSET:   reg_sel = 2'h2;
         default:       reg_sel = 2'h3;
      endcase
   endfunction : reg_sel

   mst_state_t state, next_state;
   ctrl_t      ctrl, next_ctrl;
   logic [7:0] code, next_code, data, next_data, shifter, next_shifter;
   logic [1:0] presc, next_presc;
   logic [3:0] cnt, next_cnt;
   logic       owning, next_owning, addr_phase, next_addr_phase, restart, next_restart;
   logic       pending, next_pending, busy, next_busy;
   logic       next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic       scl_meta, scl_sync, sda_meta, sda_sync, sda_prev;
   logic       wr_go, rd_go, eng_go, eng_ready, eng_done, eng_rx, eng_lost, eng_tx;
   bus_cmd_t   eng_cmd;

   assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_wready  = s_axi_awready;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go         = s_axi_awready;
   assign rd_go         = s_axi_arvalid && s_axi_arready;
   assign scl_out       = 1'b0;
   assign sda_out       = 1'b0;
   assign irq           = ctrl.flag && ctrl.irq_enable;

   // engine command for the active step; the ack slot is sent released
   assign eng_go  = (state == M_START || state == M_STOP || state == M_BYTE) && eng_ready && !pending
                    && !ctrl.flag;
   assign eng_cmd = (state == M_START) ? CMD_START : (state == M_STOP) ? CMD_STOP
                    : (cnt == 4'(BYTE_BITS)) ? CMD_ACK : CMD_BIT;
   assign eng_tx  = (cnt == 4'(BYTE_BITS)) ? 1'b1 : shifter[7];

   two_wire_bit_engine #(
      .QUARTER   (QUARTER)
   ) u_engine (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .go        (eng_go),
      .cmd       (eng_cmd),
      .tx_bit    (eng_tx),
      .abort     (!ctrl.enable),
      .ready     (eng_ready),
      .done      (eng_done),
      .rx_bit    (eng_rx),
      .arb_lost  (eng_lost),
      .scl_level (scl_sync),
      .sda_level (sda_sync),
      .scl_oe    (scl_oe),
      .sda_oe    (sda_oe)
   );

   always_comb
   begin
      next_ctrl       = ctrl;
      next_code       = code;
      next_data       = data;
      next_presc      = presc;
      next_shifter    = shifter;
      next_cnt        = cnt;
      next_state      = state;
      next_owning     = owning;
      next_addr_phase = addr_phase;
      next_restart    = restart;
      next_pending    = pending;
      next_busy       = busy;
      next_bvalid     = s_axi_bvalid && !s_axi_bready;
      next_bresp      = s_axi_bresp;
      next_rvalid     = s_axi_rvalid && !s_axi_rready;
      next_rresp      = s_axi_rresp;
      next_rdata      = s_axi_rdata;

      // bus-free tracking from start and stop conditions seen on the wires
      if (scl_sync && sda_prev && !sda_sync)
         next_busy = 1'b1;
      else if (scl_sync && !sda_prev && sda_sync)
         next_busy = 1'b0;

      // register writes
      if (wr_go)
      begin
         next_bvalid = 1'b1;
         next_bresp  = RESP_OKAY;
         if (s_axi_wstrb[0])
         begin
            case (reg_sel(s_axi_awaddr))
               2'h0:
               begin
                  next_ctrl.flag       = ctrl.flag && !s_axi_wdata[FLAG_BIT];
                  next_ctrl.ack_enable = s_axi_wdata[6];
                  next_ctrl.start_req  = s_axi_wdata[5];
                  next_ctrl.stop_req   = s_axi_wdata[4];
                  next_ctrl.enable     = s_axi_wdata[2];
                  next_ctrl.irq_enable = s_axi_wdata[0];
               end
               2'h1: next_presc = s_axi_wdata[1:0];
               2'h2:
               begin
                  if (ctrl.flag)
                  begin
                     next_data                 = s_axi_wdata[7:0];
                     next_ctrl.write_collision = 1'b0;
                  end
                  else
                     next_ctrl.write_collision = 1'b1;
               end
               default: next_bresp = RESP_SLVERR;
            endcase
         end
         else if (reg_sel(s_axi_awaddr) == 2'h3)
            next_bresp = RESP_SLVERR;
      end

      // register reads
      if (rd_go)
      begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         case (reg_sel(s_axi_araddr))
            2'h0:    next_rdata = {24'h000000, ctrl};
            2'h1:    next_rdata = {24'h000000, code[7:CODE_LSB], 1'b0, presc};
            2'h2:    next_rdata = {24'h000000, data};
            default:
            begin
               next_rdata = 32'h00000000;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end

      // master sequencer; hardware flag set wins over a software clear
      if (eng_go)
         next_pending = 1'b1;
      if (eng_done)
         next_pending = 1'b0;
      case (state)
         M_IDLE:
         begin
            // only master transmit is served; slave modes stay off
            if (ctrl.enable && !ctrl.flag && ctrl.start_req)
               next_state = M_WAIT_FREE;
         end
         M_WAIT_FREE:
         begin
            if (!busy)
            begin
               next_state   = M_START;
               next_restart = 1'b0;
            end
         end
         M_START:
         begin
            if (eng_done)
            begin
               next_ctrl.flag  = 1'b1;
               next_code       = restart ? STS_RESTART : STS_START;
               next_owning     = 1'b1;
               next_addr_phase = 1'b1;
               next_state      = M_HOLD;
            end
         end
         M_HOLD:
         begin
            if (!ctrl.flag)
            begin
               if (!owning)
                  next_state = ctrl.start_req ? M_WAIT_FREE : M_IDLE;
               else if (ctrl.stop_req)
                  next_state = M_STOP;
               else if (ctrl.start_req)
               begin
                  next_state   = M_START;
                  next_restart = 1'b1;
               end
               else
               begin
                  next_state   = M_BYTE;
                  next_shifter = data;
                  next_cnt     = 4'h0;
               end
            end
         end
         M_BYTE:
         begin
            if (eng_done)
            begin
               if (eng_lost)
               begin
                  next_ctrl.flag = 1'b1;
                  next_code      = STS_ARB_LOST;
                  next_owning    = 1'b0;
                  next_state     = M_HOLD;
               end
               else if (cnt == 4'(BYTE_BITS))
               begin
                  next_ctrl.flag  = 1'b1;
                  next_addr_phase = 1'b0;
                  next_state      = M_HOLD;
                  if (addr_phase)
                     next_code = eng_rx ? STS_ADDR_NACK : STS_ADDR_ACK;
                  else
                     next_code = eng_rx ? STS_DATA_NACK : STS_DATA_ACK;
               end
               else
               begin
                  next_shifter = {shifter[6:0], 1'b0};
                  next_cnt     = cnt + 4'h1;
               end
            end
         end
         M_STOP:
         begin
            if (eng_done)
            begin
               next_ctrl.stop_req = 1'b0;
               next_owning        = 1'b0;
               next_state         = ctrl.start_req ? M_WAIT_FREE : M_IDLE;
            end
         end
         default: next_state = M_IDLE;
      endcase

      if (!ctrl.enable)
      begin
         next_state   = M_IDLE;
         next_owning  = 1'b0;
         next_pending = 1'b0;
      end
      next_ctrl.reserved = 1'b0;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
      end
      else
      begin
         scl_meta <= scl_in;
         scl_sync <= scl_meta;
         sda_meta <= sda_in;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state        <= M_IDLE;
         ctrl         <= CTRL_RESET;
         code         <= STS_NO_INFO;
         data         <= DATA_RESET;
         presc        <= PRESC_RESET;
         shifter      <= DATA_RESET;
         cnt          <= 4'h0;
         owning       <= 1'b0;
         addr_phase   <= 1'b0;
         restart      <= 1'b0;
         pending      <= 1'b0;
         busy         <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
      end
      else
      begin
         state        <= next_state;
         ctrl         <= next_ctrl;
         code         <= next_code;
         data         <= next_data;
         presc        <= next_presc;
         shifter      <= next_shifter;
         cnt          <= next_cnt;
         owning       <= next_owning;
         addr_phase   <= next_addr_phase;
         restart      <= next_restart;
         pending      <= next_pending;
         busy         <= next_busy;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp  <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp  <= next_rresp;
         s_axi_rdata  <= next_rdata;
      end
   end

   property p_start_code;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == M_START && eng_done && ctrl.enable) |=> ctrl.flag && (code == (restart ? STS_RESTART : STS_START));
   endproperty
   a_start_code: assert property (p_start_code) else $error("start status wrong");

   property p_wait_free;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == M_WAIT_FREE && busy) |=> state != M_START;
   endproperty
   a_wait_free: assert property (p_wait_free) else $error("start issued on busy bus");

   property p_addr_code;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == M_BYTE && eng_done && !eng_lost && cnt == 4'h8 && addr_phase && ctrl.enable)
         |=> ctrl.flag && code == (eng_rx ? STS_ADDR_NACK : STS_ADDR_ACK) && state == M_HOLD;
   endproperty
   a_addr_code: assert property (p_addr_code) else $error("address status wrong");

   property p_data_code;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == M_BYTE && eng_done && !eng_lost && cnt == 4'h8 && !addr_phase && ctrl.enable)
         |=> code == ($past(eng_rx) ? STS_DATA_NACK : STS_DATA_ACK);
   endproperty
   a_data_code: assert property (p_data_code) else $error("data status wrong");

   property p_collision;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_go && s_axi_wstrb[0] && s_axi_awaddr == DATA_OFFSET && !ctrl.flag)
         |=> ctrl.write_collision && $stable(data);
   endproperty
   a_collision: assert property (p_collision) else $error("collision write not ignored");

   property p_suspend;
      @(posedge sys_clk) disable iff (!rst_n)
      ctrl.flag |-> !eng_go && eng_ready;
   endproperty
   a_suspend: assert property (p_suspend) else $error("bus step while flag set");

   property p_no_flag_stop;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == M_STOP && eng_done) |=> !ctrl.flag && !owning && !ctrl.stop_req;
   endproperty
   a_no_flag_stop: assert property (p_no_flag_stop) else $error("flag set after stop");

   property p_scl_held;
      @(posedge sys_clk) disable iff (!rst_n)
      (ctrl.flag && owning && state == M_HOLD) ##1 (ctrl.flag && owning) |-> scl_oe;
   endproperty
   a_scl_held: assert property (p_scl_held) else $error("scl released while flag set");

   property p_lost;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == M_BYTE && eng_done && eng_lost && ctrl.enable)
         |=> code == STS_ARB_LOST && !owning && ctrl.flag && !scl_oe;
   endproperty
   a_lost: assert property (p_lost) else $error("lost arbitration not reported");

   property p_irq;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(ctrl.flag) && ctrl.irq_enable |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt request missing");

endmodule : two_wire_unit

// ==== rtl/two_wire_pkg.sv ====
/*
 * Constants, register map and carrier types for the two-wire master transmitter.
 * Assumes a single 125 MHz system clock and a 32-bit AXI4-Lite register port.
 */
package two_wire_pkg;

   // register map, byte addresses
   localparam int         ADDR_W        = 4;
   localparam logic [3:0] CTRL_OFFSET   = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [3:0] DATA_OFFSET   = 4'h8;

   // control register layout, msb first
   typedef struct packed {
      logic flag;
      logic ack_enable;
      logic start_req;
      logic stop_req;
      logic write_collision;
      logic enable;
      logic reserved;
      logic irq_enable;
   } ctrl_t;

   localparam ctrl_t      CTRL_RESET  = 8'h00;
   localparam logic [7:0] DATA_RESET  = 8'hff;
   localparam logic [1:0] PRESC_RESET = 2'h0;
   localparam int         CODE_LSB    = 3;
   localparam int         FLAG_BIT    = 7;

   // status codes, prescaler bits masked
   localparam logic [7:0] STS_START        = 8'h08;
   localparam logic [7:0] STS_RESTART      = 8'h10;
   localparam logic [7:0] STS_ADDR_ACK     = 8'h18;
   localparam logic [7:0] STS_ADDR_NACK    = 8'h20;
   localparam logic [7:0] STS_DATA_ACK     = 8'h28;
   localparam logic [7:0] STS_DATA_NACK    = 8'h30;
   localparam logic [7:0] STS_ARB_LOST     = 8'h38;
   localparam logic [7:0] STS_NO_INFO      = 8'hf8;
   localparam logic [7:0] STATUS_CODE_MASK = 8'hf8;

   // bus timing
   localparam int CLK_FREQ_MHZ   = 125;
   localparam int BIT_PERIOD_NS  = 10000;
   localparam int QUARTER_CYCLES = (BIT_PERIOD_NS * CLK_FREQ_MHZ) / (4 * 1000);
   localparam int BYTE_BITS      = 8;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      CMD_START = 2'b00,
      CMD_STOP  = 2'b01,
      CMD_BIT   = 2'b10,
      // ack slot: sent released, never an arbitration loss
      CMD_ACK   = 2'b11
   } bus_cmd_t;

endpackage : two_wire_pkg

// ==== rtl/two_wire_bit_engine.sv ====
/*
 * Bit-level engine: one START, STOP or data bit per command, in four quarter-bit phases.
 * Assumes synchronised bus inputs and open-drain pads driven low while an enable is high.
 */
module two_wire_bit_engine
   import two_wire_pkg::*;
#(
   parameter int QUARTER = QUARTER_CYCLES
)
(
   // clock and reset
   input  wire logic     sys_clk,
   input  wire logic     rst_n,
   // command side
   input  wire logic     go,
   input  wire bus_cmd_t cmd,
   input  wire logic     tx_bit,
   input  wire logic     abort,
   output logic          ready,
   output logic          done,
   output logic          rx_bit,
   output logic          arb_lost,
   // synchronised bus levels
   input  wire logic     scl_level,
   input  wire logic     sda_level,
   // pad enables
   output logic          scl_oe,
   output logic          sda_oe
);

   typedef enum logic {
      ENG_IDLE = 1'b0,
      ENG_RUN  = 1'b1
   } eng_state_t;

   eng_state_t  state, next_state;
   bus_cmd_t    cur_cmd, next_cur_cmd;
   logic        cur_bit, next_cur_bit;
   logic [1:0]  phase, next_phase;
   logic [15:0] div, next_div;
   logic        next_scl_oe, next_sda_oe, next_rx_bit, next_arb_lost, next_done;
   logic        tick;

   assign tick  = (div == 16'(QUARTER - 1));
   assign ready = (state == ENG_IDLE);

   always_comb
   begin
      next_state    = state;
      next_cur_cmd  = cur_cmd;
      next_cur_bit  = cur_bit;
      next_phase    = phase;
      next_div      = tick ? 16'h0000 : div + 16'h0001;
      next_scl_oe   = scl_oe;
      next_sda_oe   = sda_oe;
      next_rx_bit   = rx_bit;
      next_arb_lost = arb_lost;
      next_done     = 1'b0;
      if (abort)
      begin
         next_state  = ENG_IDLE;
         next_scl_oe = 1'b0;
         next_sda_oe = 1'b0;
      end
      else if (state == ENG_IDLE)
      begin
         next_div = 16'h0000;
         if (go)
         begin
            next_state    = ENG_RUN;
            next_cur_cmd  = cmd;
            next_cur_bit  = tx_bit;
            next_phase    = 2'h0;
            next_arb_lost = 1'b0;
            case (cmd)
               CMD_START: next_sda_oe = 1'b0;
               CMD_STOP:  next_sda_oe = 1'b1;
               default:   next_sda_oe = ~tx_bit;
            endcase
         end
      end
      else if (tick)
      begin
         case (phase)
            2'h0:
            begin
               next_scl_oe = 1'b0;
               next_phase  = 2'h1;
            end
            2'h1:
            begin
               // slave may stretch scl; wait for it high
               if (scl_level)
               begin
                  next_phase = 2'h2;
                  case (cur_cmd)
                     CMD_START: next_sda_oe = 1'b1;
                     CMD_STOP:  next_sda_oe = 1'b0;
                     default:
                     begin
                        next_rx_bit = sda_level;
                        if (cur_cmd == CMD_BIT && cur_bit && !sda_level)
                        begin
                           next_arb_lost = 1'b1;
                           next_sda_oe   = 1'b0;
                        end
                     end
                  endcase
               end
            end
            2'h2:
            begin
               next_phase = 2'h3;
               if (cur_cmd != CMD_STOP)
                  next_scl_oe = ~arb_lost;
            end
            default:
            begin
               next_state = ENG_IDLE;
               next_done  = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state    <= ENG_IDLE;
         cur_cmd  <= CMD_START;
         cur_bit  <= 1'b1;
         phase    <= 2'h0;
         div      <= 16'h0000;
         scl_oe   <= 1'b0;
         sda_oe   <= 1'b0;
         rx_bit   <= 1'b1;
         arb_lost <= 1'b0;
         done     <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         cur_cmd  <= next_cur_cmd;
         cur_bit  <= next_cur_bit;
         phase    <= next_phase;
         div      <= next_div;
         scl_oe   <= next_scl_oe;
         sda_oe   <= next_sda_oe;
         rx_bit   <= next_rx_bit;
         arb_lost <= next_arb_lost;
         done     <= next_done;
      end
   end

   property p_lost_releases;
      @(posedge sys_clk) disable iff (!rst_n)
      (!abort && state == ENG_RUN && cur_cmd == CMD_BIT && phase == 2'h1 && tick && scl_level && cur_bit
       && !sda_level)
         |=> !sda_oe && arb_lost ##1 !sda_oe [*3];
   endproperty
   a_lost_releases: assert property (p_lost_releases) else $error("sda held after lost arbitration");

endmodule : two_wire_bit_engine

// ==== verif/twi_slave_model.sv ====
/* slave receiver model: acks each byte unless told not to, and can hold sda low like a rival master.
   assumes pull-ups on both lines resolved by the bench */
module bus_slave_model
(
   // bus side
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic nack,
   input  wire logic grab,
   output logic      sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   int         bits = 0;
   logic [7:0] rx;
   logic [7:0] got[$];
   logic       ack_oe = 1'h0;
   // grab pulls sda low at once, as a competing master would
   assign sda_oe = ack_oe || grab;
   // start or repeated start restarts the count
   always @(negedge sda) if (scl) bits = 0;
   always @(posedge scl)
   begin
      rx = {rx[6:0], sda};
      bits++;
   end
   always @(negedge scl)
   begin
      if (bits == 8) got.push_back(rx);
      ack_oe <= (bits == 8) && !nack;
      if (bits == 9) bits = 0;
   end
endmodule : bus_slave_model

// ==== verif/two_wire_unit_test.sv ====
/* self-checking bench for the two-wire master transmitter.
   assumes the slave model and pull-ups on both lines */
module two_wire_unit_test
   import two_wire_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int Q = 4;
   localparam logic [7:0] CODES [6] = '{STS_ADDR_ACK, STS_DATA_ACK, STS_DATA_ACK, STS_RESTART, STS_ADDR_NACK,
                                        STS_DATA_NACK};
   typedef struct packed {logic [7:0] d; logic [7:0] m; logic [1:0] r;} exp_t;
   logic sys_clk = 1'h0, rst_n = 1'h0, nack = 1'h0, slv_oe, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, grab = 1'h0;
   logic s_axi_awready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, scl_oe, sda_oe, irq;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic [15:0] seed = 16'h26c1;
   int err_count = 0, comparisons = 0, w;
   exp_t expq[$];
   wire scl = !scl_oe;
   wire sda = !(sda_oe || slv_oe);
   always #4 sys_clk = !sys_clk;
   two_wire_unit #(.QUARTER(Q)) dut (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in(scl), .scl_out(), .scl_oe,
      .sda_in(sda), .sda_out(), .sda_oe, .irq);
   bus_slave_model partner (.scl, .sda, .nack, .grab, .sda_oe(slv_oe));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // bounded wait step
   task automatic guard;
      @(negedge sys_clk);
      w++;
      if (w > 5000)
      begin
         err_count++;
         $display("Error %0t wait timed out", $time);
         finish_test();
      end
   endtask : guard
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, 24'h0, d, 3'h7};
      w = 0;
      do guard(); while (!s_axi_awready);
      @(posedge sys_clk) {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
      do guard(); while (!s_axi_bvalid);
      @(posedge sys_clk) s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input exp_t e);
      expq.push_back(e);
      @(posedge sys_clk) {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      w = 0;
      do guard(); while (!s_axi_arready);
      @(posedge sys_clk) s_axi_arvalid <= 1'h0;
      do guard(); while (!s_axi_rvalid);
      @(posedge sys_clk) s_axi_rready <= 1'h0;
   endtask : rd
   // control write, wait for the flag, then status
   task automatic step(input logic [7:0] c, input logic [7:0] st, input logic hold = 1'h1);
      wr(CTRL_OFFSET, c);
      w = 0;
      do guard(); while (!irq);
      rd(STATUS_OFFSET, '{st, STATUS_CODE_MASK, RESP_OKAY});
      check({9'h0, scl_oe}, {9'h0, hold});
   endtask : step
   always @(negedge sys_clk)
      if (s_axi_rvalid && s_axi_rready && expq.size() > 0)
      begin
         exp_t e;
         e = expq.pop_front();
         check({s_axi_rresp, s_axi_rdata[7:0] & e.m}, {e.r, e.d});
      end
   initial
   begin
      logic [7:0] b;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'h1;
      rd(CTRL_OFFSET, '{CTRL_RESET, 8'hff, RESP_OKAY});
      rd(4'hc, '{8'h00, 8'hff, RESP_SLVERR});
      wr(DATA_OFFSET, 8'h5a);
      rd(CTRL_OFFSET, '{8'h08, 8'h08, RESP_OKAY});
      rd(DATA_OFFSET, '{DATA_RESET, 8'hff, RESP_OKAY});
      step(8'ha5, STS_START);
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         nack = (i > 3);
         b = (i == 0) ? {seed[6:0], 1'h0} : (i == 4) ? {seed[6:0], 1'h1} : seed[15:8];
         if (i != 3) wr(DATA_OFFSET, b);
         if (i == 0) rd(CTRL_OFFSET, '{8'h80, 8'h88, RESP_OKAY});
         step((i == 3) ? 8'ha5 : 8'h85, CODES[i]);
         if (i != 3) check({2'h0, partner.got.pop_front()}, {2'h0, b});
      end
      wr(CTRL_OFFSET, 8'h95);
      repeat (40 * Q) @(posedge sys_clk);
      rd(CTRL_OFFSET, '{8'h00, 8'h90, RESP_OKAY});
      check({7'h0, irq, scl, sda}, 10'h3);
      // a rival holding sda low wins the first address bit
      seed = lfsr(seed);
      step(8'ha5, STS_START);
      grab <= 1'h1;
      wr(DATA_OFFSET, {1'h1, seed[6:0]});
      step(8'h85, STS_ARB_LOST, 1'h0);
      grab <= 1'h0;
      wr(CTRL_OFFSET, 8'h85);
      rd(CTRL_OFFSET, '{8'h00, 8'hb0, RESP_OKAY});
      check({7'h0, scl_oe, sda_oe, partner.got.size() == 0}, 10'h1);
      finish_test();
   end
endmodule : two_wire_unit_test
